// File: core/ecsi_pkg.sv
/*
 * Constants of the host command, status and interrupt-enable registers.
 * Assumes a 125 MHz controller clock and a 32-bit APB register port.
 */
package ecsi_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W           = 8;
    localparam logic [7:0]  OFF_HOST_COMMAND = 8'h10;
    localparam logic [7:0]  OFF_EVENT_STATUS = 8'h14;
    localparam logic [7:0]  OFF_EVENT_ENABLE = 8'h18;

    // ------------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------------
    localparam int CMD_RUN_STOP   = 0;
    localparam int CMD_SOFT_RESET = 1;
    localparam int CMD_FLS_LO     = 2;
    localparam int CMD_PER_EN     = 4;
    localparam int CMD_ASYNC_EN   = 5;
    localparam int CMD_DOORBELL   = 6;
    localparam int CMD_PARK_CNT   = 8;
    localparam int CMD_PARK_EN    = 11;
    localparam int CMD_THR_LO     = 16;

    localparam logic [7:0] THR_RESET  = 8'h08;
    localparam logic [7:0] THR_NOLIM  = 8'h01;
    localparam logic [1:0] PKC_RESET  = 2'h3;
    localparam logic       PKE_RESET  = 1'h1;
    localparam logic [1:0] FLS_RESET  = 2'h0;
    localparam logic [1:0] FLS_RSVD   = 2'h3;

    // ------------------------------------------------------------------
    // Status register fields; flags share positions with the enables
    // ------------------------------------------------------------------
    localparam int NUM_FLAGS     = 6;
    localparam int FLG_DONE      = 0;
    localparam int FLG_ERROR     = 1;
    localparam int FLG_PORT      = 2;
    localparam int FLG_WRAP      = 3;
    localparam int FLG_SYSERR    = 4;
    localparam int FLG_ADVANCE   = 5;
    localparam int STS_HALTED    = 12;
    localparam int STS_RECLAIM   = 13;
    localparam int STS_PER_STATE = 14;
    localparam int STS_ASY_STATE = 15;
    localparam logic       HALTED_RESET = 1'h1;
    localparam logic [5:0] DELAYED_MASK = 6'h23;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int UFRAME_NS     = 125000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int UFRAME_CYCLES = UFRAME_NS / CLK_PERIOD_NS;

    function automatic logic thr_valid(input logic [7:0] v);
        return v inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    endfunction : thr_valid

endpackage : ecsi_pkg

// File: core/ecsi_flag.sv
/*
 * One sticky event flag, set by hardware and cleared by writing one.
 * Assumes set and clear are one-cycle qualified strobes from the owner.
 */
`timescale 1ns/1ns
module ecsi_flag (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } ecsi_flag_t;

    ecsi_flag_t st;
    ecsi_flag_t next_st;

    // Set wins over a clear in the same cycle
    always_comb begin
        next_st = st;
        if (set) begin
            next_st.flag = 1'h1;
        end else if (clr) begin
            next_st.flag = 1'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_flag_w1c: assert property (clr && !set |=> !flag)
        else $error("flag not cleared by write of one");
    chk_flag_hold: assert property (!clr && flag |=> flag)
        else $error("flag lost without a clear");
endmodule : ecsi_flag

// File: core/ecsi_uframe_timer.sv
/*
 * Micro-frame divider and interrupt threshold boundary generator.
 * Assumes the threshold value is one of the valid power-of-two codes.
 */
`timescale 1ns/1ns
module ecsi_uframe_timer #(
    parameter int UFRAME_CYCLES = ecsi_pkg::UFRAME_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] threshold,
    output logic            boundary
);
    import ecsi_pkg::*;

    localparam int DIV_W = $clog2(UFRAME_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UFRAME_CYCLES - 1);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [7:0]       uframes;
        logic             boundary;
    } ecsi_timer_t;

    ecsi_timer_t st;
    ecsi_timer_t next_st;

    // Boundary pulses after every threshold count of micro-frames
    always_comb begin
        next_st = st;
        next_st.boundary = 1'h0;
        if (st.div == DIV_LAST) begin
            next_st.div = '0;
            if (st.uframes + 8'h01 >= threshold) begin
                next_st.uframes  = 8'h00;
                next_st.boundary = 1'h1;
            end else begin
                next_st.uframes = st.uframes + 8'h01;
            end
        end else begin
            next_st.div = st.div + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign boundary = st.boundary;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_boundary_cause: assert property (boundary
        |-> $past(st.div) == DIV_LAST)
        else $error("threshold boundary off the micro-frame edge");
endmodule : ecsi_uframe_timer

// File: core/ecsi_regs.sv
/*
 * Command, status and interrupt-enable registers of the host controller,
 * reached over APB, with interrupt threshold and edge-width gating.
 * Assumes controller events are one-cycle pulses on clk_sys and schedule
 * state inputs are levels synchronous to clk_sys.
 */
// The APB slave port was left to the implementer.
// Contract
// - Threshold field of 8 bits, valid 01h..40h powers of two, reset 08h.
// - Threshold 01h: enabled events raise the interrupt at once.
// - Edge signalling adds a minimum pulse width; full-speed ignores threshold.
// - Park mode enable bit drives park mode, resets to one.
// - Two-bit park count limits consecutive queue-head transactions, resets 11.
// - Doorbell write makes the next async advance set the advance flag.
// - Async schedule skipped while its enable is zero, else fetched.
// - Periodic schedule skipped while its enable is zero, else fetched.
// - Frame list size code: 00=1024, 01=512, 10=256, 11 reserved.
// - Writing one to the soft reset bit resets the controller.
// - Run/stop starts and stops schedules, resets to zero.
// - Halted is zero while running, one once stopped, resets one.
// - Event flags clear on write of one; zero leaves them.
// - Actual async and periodic schedule states readable as status.
// - Reclamation status shows an empty async schedule.
// - Host system error sets the system error flag.
// - Frame list index wrap sets the wrap flag.
// - Port change flag set on rise and loaded with OR of changes.
// - Transaction error and completion set their flags.
// - Interrupt only when flag and enable both set; flags still recorded.
// - Advance, error and completion interrupts wait for threshold boundary.
`timescale 1ns/1ns
module ecsi_regs #(
    parameter int NUM_PORTS     = 1,
    parameter int UFRAME_CYCLES = ecsi_pkg::UFRAME_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ecsi_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        async_advanced,
    input  wire logic                        system_error,
    input  wire logic                        frame_index_wrap,
    input  wire logic [NUM_PORTS-1:0]        port_change_bits,
    input  wire logic                        transfer_error,
    input  wire logic                        transfer_done,
    input  wire logic                        async_running,
    input  wire logic                        periodic_running,
    input  wire logic                        async_list_empty,
    input  wire logic                        execution_stopped,
    input  wire logic                        full_speed_mode,
    input  wire logic                        edge_irq_control,
    input  wire logic [7:0]                  irq_min_width,
    output logic                             run_stop,
    output logic                             controller_soft_reset,
    output logic                             async_schedule_enable,
    output logic                             periodic_schedule_enable,
    output logic      [1:0]                  frame_list_size,
    output logic                             park_mode_enable,
    output logic      [1:0]                  park_mode_count,
    output logic      [7:0]                  irq_rate_threshold,
    output logic                             irq
);
    import ecsi_pkg::*;

    typedef struct packed {
        logic                 run_stop;
        logic                 soft_reset;
        logic                 async_en;
        logic                 per_en;
        logic [1:0]           fl_size;
        logic                 park_en;
        logic [1:0]           park_cnt;
        logic                 doorbell;
        logic [7:0]           thresh;
        logic                 halted;
        logic [5:0]           irq_en;
        logic [5:0]           released;
        logic [NUM_PORTS-1:0] port_prev;
        logic [7:0]           width_cnt;
        logic                 req_prev;
        logic                 irq;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } ecsi_regs_t;

    ecsi_regs_t st;
    ecsi_regs_t next_st;

    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic                 boundary;
    logic                 no_limit;
    logic                 req;
    logic                 acc_wr;
    logic                 setup;
    logic                 wr_cmd;
    logic                 wr_sts;
    logic                 wr_en;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign setup  = psel && !penable;
    assign acc_wr = psel && penable && st.pready && pwrite;
    assign wr_cmd = acc_wr && paddr == OFF_HOST_COMMAND;
    assign wr_sts = acc_wr && paddr == OFF_EVENT_STATUS;
    assign wr_en  = acc_wr && paddr == OFF_EVENT_ENABLE;

    // ------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------
    always_comb begin
        flag_set              = '0;
        flag_set[FLG_DONE]    = transfer_done;
        flag_set[FLG_ERROR]   = transfer_error;
        flag_set[FLG_PORT]    = |(port_change_bits & ~st.port_prev)
                                || |port_change_bits;
        flag_set[FLG_WRAP]    = frame_index_wrap;
        flag_set[FLG_SYSERR]  = system_error;
        flag_set[FLG_ADVANCE] = async_advanced && st.doorbell;
        flag_clr = wr_sts ? pwdata[NUM_FLAGS-1:0] : '0;
    end

    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        ecsi_flag u_flag (
            .clk_sys (clk_sys),
            .rst     (rst || st.soft_reset),
            .set     (flag_set[i]),
            .clr     (flag_clr[i]),
            .flag    (flags[i])
        );
    end

    ecsi_uframe_timer #(
        .UFRAME_CYCLES (UFRAME_CYCLES)
    ) u_timer (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .threshold (st.thresh),
        .boundary  (boundary)
    );

    // Full-speed operation treats the threshold as absent
    assign no_limit = st.thresh == THR_NOLIM || full_speed_mode;
    assign req = |(flags & st.irq_en & ~DELAYED_MASK)
                 || |(st.released & st.irq_en);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.soft_reset = 1'h0;
        next_st.port_prev  = port_change_bits;

        if (wr_cmd) begin
            next_st.run_stop = pwdata[CMD_RUN_STOP];
            next_st.per_en   = pwdata[CMD_PER_EN];
            next_st.async_en = pwdata[CMD_ASYNC_EN];
            next_st.park_en  = pwdata[CMD_PARK_EN];
            next_st.park_cnt = pwdata[CMD_PARK_CNT +: 2];
            if (pwdata[CMD_DOORBELL]) begin
                next_st.doorbell = 1'h1;
            end
            if (pwdata[CMD_FLS_LO +: 2] != FLS_RSVD) begin
                next_st.fl_size = pwdata[CMD_FLS_LO +: 2];
            end
            if (thr_valid(pwdata[CMD_THR_LO +: 8])) begin
                next_st.thresh = pwdata[CMD_THR_LO +: 8];
            end
        end
        if (wr_en) begin
            next_st.irq_en = pwdata[NUM_FLAGS-1:0];
        end
        if (flag_set[FLG_ADVANCE]) begin
            next_st.doorbell = 1'h0;
        end

        // Halted drops in the same cycle that run/stop is set
        if (next_st.run_stop) begin
            next_st.halted = 1'h0;
        end else if (execution_stopped) begin
            next_st.halted = 1'h1;
        end

        // Deferred events pass at a threshold boundary, or at once with no limit
        next_st.released = st.released & flags & DELAYED_MASK;
        if (boundary || no_limit) begin
            next_st.released = flags & DELAYED_MASK;
        end

        // Interrupt line: level, or stretched pulse in edge mode
        next_st.req_prev = req;
        if (edge_irq_control) begin
            if (st.width_cnt != 8'h00) begin
                next_st.width_cnt = st.width_cnt - 8'h01;
            end else if (req && !st.req_prev) begin
                next_st.width_cnt = irq_min_width;
            end
            next_st.irq = st.width_cnt != 8'h00
                          || (req && !st.req_prev);
        end else begin
            next_st.width_cnt = 8'h00;
            next_st.irq       = req;
        end

        // APB answer is prepared in the setup cycle
        next_st.pready  = setup;
        next_st.pslverr = 1'h0;
        next_st.prdata  = '0;
        if (setup) begin
            unique case (paddr)
                OFF_HOST_COMMAND: begin
                    next_st.prdata[CMD_THR_LO +: 8]   = st.thresh;
                    next_st.prdata[CMD_PARK_EN]       = st.park_en;
                    next_st.prdata[CMD_PARK_CNT +: 2] = st.park_cnt;
                    next_st.prdata[CMD_DOORBELL]      = st.doorbell;
                    next_st.prdata[CMD_ASYNC_EN]      = st.async_en;
                    next_st.prdata[CMD_PER_EN]        = st.per_en;
                    next_st.prdata[CMD_FLS_LO +: 2]   = st.fl_size;
                    next_st.prdata[CMD_SOFT_RESET]    = st.soft_reset;
                    next_st.prdata[CMD_RUN_STOP]      = st.run_stop;
                end
                OFF_EVENT_STATUS: begin
                    next_st.prdata[STS_ASY_STATE] = async_running;
                    next_st.prdata[STS_PER_STATE] = periodic_running;
                    next_st.prdata[STS_RECLAIM] = async_list_empty;
                    next_st.prdata[STS_HALTED]    = st.halted;
                    next_st.prdata[NUM_FLAGS-1:0] = flags;
                end
                OFF_EVENT_ENABLE: begin
                    next_st.prdata[NUM_FLAGS-1:0] = st.irq_en;
                end
                default: begin
                    next_st.pslverr = 1'h1;
                end
            endcase
        end

        // Soft reset returns command fields, halted, enables and released events to reset values
        if (wr_cmd && pwdata[CMD_SOFT_RESET]) begin
            next_st.run_stop   = 1'h0;
            next_st.async_en   = 1'h0;
            next_st.per_en     = 1'h0;
            next_st.fl_size    = FLS_RESET;
            next_st.park_en    = PKE_RESET;
            next_st.park_cnt   = PKC_RESET;
            next_st.doorbell   = 1'h0;
            next_st.thresh     = THR_RESET;
            next_st.halted     = HALTED_RESET;
            next_st.irq_en     = '0;
            next_st.released   = '0;
            next_st.soft_reset = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st          <= '0;
            st.fl_size  <= FLS_RESET;
            st.park_en  <= PKE_RESET;
            st.park_cnt <= PKC_RESET;
            st.thresh   <= THR_RESET;
            st.halted   <= HALTED_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata                   = st.prdata;
    assign pready                   = st.pready;
    assign pslverr                  = st.pslverr;
    assign run_stop                 = st.run_stop;
    assign controller_soft_reset    = st.soft_reset;
    assign async_schedule_enable    = st.async_en;
    assign periodic_schedule_enable = st.per_en;
    assign frame_list_size          = st.fl_size;
    assign park_mode_enable         = st.park_en;
    assign park_mode_count          = st.park_cnt;
    assign irq_rate_threshold       = st.thresh;
    assign irq                      = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_thresh_valid: assert property (thr_valid(st.thresh))
        else $error("threshold holds an invalid code");
    chk_nolimit_irq: assert property (st.thresh == THR_NOLIM
        && !edge_irq_control && flags[FLG_DONE] && st.irq_en[FLG_DONE]
        && !wr_en && !wr_sts |=> ##1 irq)
        else $error("no-limit threshold did not raise interrupt");
    chk_edge_width: assert property (edge_irq_control
        && st.width_cnt != 8'h00 |-> irq)
        else $error("edge interrupt shorter than minimum width");
    chk_fs_release: assert property (full_speed_mode
        && flags[FLG_DONE] && !wr_cmd |=> st.released[FLG_DONE])
        else $error("full-speed mode held back a deferred event");
    chk_doorbell_adv: assert property (st.doorbell && async_advanced
        |=> flags[FLG_ADVANCE] && !st.doorbell)
        else $error("doorbell not answered by advance flag");
    chk_fls_valid: assert property (st.fl_size != FLS_RSVD)
        else $error("frame list size holds reserved code");
    chk_soft_reset: assert property (wr_cmd && pwdata[CMD_SOFT_RESET]
        |=> controller_soft_reset && !run_stop && st.thresh == THR_RESET
        ##1 !controller_soft_reset)
        else $error("soft reset not applied");
    chk_halt_run: assert property (st.run_stop |-> !st.halted)
        else $error("halted while running");
    chk_sched_state: assert property (setup
        && paddr == OFF_EVENT_STATUS
        |=> prdata[STS_ASY_STATE] == $past(async_running))
        else $error("async schedule state not reported");
    chk_irq_cause: assert property (!edge_irq_control
        && !$past(edge_irq_control) && irq |-> $past(req))
        else $error("interrupt without enabled event");
    chk_defer_gate: assert property ($rose(st.released[FLG_DONE])
        |-> $past(boundary || no_limit))
        else $error("deferred event released off boundary");
    chk_port_load: assert property (|port_change_bits
        && !st.soft_reset |=> flags[FLG_PORT])
        else $error("port change flag not loaded");
    chk_rsvd_zero: assert property (pready
        |-> prdata[31:CMD_THR_LO+8] == '0)
        else $error("reserved command bits read nonzero");
    chk_apb_ready: assert property (setup |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");

    cov_status_read: cover property (setup && !pwrite
        && paddr == OFF_EVENT_STATUS);
    cov_doorbell: cover property (st.doorbell ##[1:100] flags[FLG_ADVANCE]);
    cov_irq_rise: cover property ($rose(irq));
    cov_soft_reset: cover property (controller_soft_reset);
    cov_edge_pulse: cover property (edge_irq_control && $rose(irq));
endmodule : ecsi_regs

// File: bench/ecsi_core_model.sv
/* Behavioural controller core facing the register block.
   Assumes the bench requests one event at a time on fire. */
`timescale 1ns/1ns
module ecsi_core_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [5:0] fire,
    input  wire logic       run_stop,
    input  wire logic       async_schedule_enable,
    input  wire logic       periodic_schedule_enable,
    output logic      [5:0] ev,
    output logic            async_running,
    output logic            periodic_running,
    output logic            async_list_empty,
    output logic            execution_stopped
);
    logic [1:0] stop_q;
    // Stopping takes two cycles after run_stop falls
    always_ff @(posedge clk_sys) begin
        ev     <= rst ? 6'h00 : fire;
        stop_q <= rst ? 2'h3 : {stop_q[0], !run_stop};
    end
    assign execution_stopped = stop_q[1];
    assign async_running     = run_stop & async_schedule_enable;
    assign periodic_running  = run_stop & periodic_schedule_enable;
    assign async_list_empty  = async_schedule_enable & !run_stop;
endmodule : ecsi_core_model

// File: bench/tb_top.sv
/* Self-checking bench of the command, status and enable registers.
   Assumes zero-wait APB answers and a shortened micro-frame of 8. */
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0, prdata;
    logic [5:0]  fire    = 6'h00, ev;
    logic        pready, pslverr, rs, ase, pse, irq, ar, pr, ae, es;
    logic        edge_ctl = 0, fs = 0;
    logic [7:0]  min_w = 8'h00;
    logic [13:0] cfg;
    logic [32:0] q[$];
    int          n_mismatch = 0, checks = 0;
    always #4 clk_sys = ~clk_sys;
    ecsi_regs #(.UFRAME_CYCLES(8)) DUT (.clk_sys, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .async_advanced(ev[5]), .system_error(ev[4]),
        .frame_index_wrap(ev[3]), .port_change_bits(ev[2:2]),
        .transfer_error(ev[1]), .transfer_done(ev[0]),
        .async_running(ar), .periodic_running(pr), .async_list_empty(ae),
        .execution_stopped(es), .full_speed_mode(fs),
        .edge_irq_control(edge_ctl), .irq_min_width(min_w), .run_stop(rs),
        .controller_soft_reset(cfg[13]), .async_schedule_enable(ase),
        .periodic_schedule_enable(pse), .frame_list_size(cfg[12:11]),
        .park_mode_enable(cfg[10]), .park_mode_count(cfg[9:8]),
        .irq_rate_threshold(cfg[7:0]), .irq);
    ecsi_core_model core (.clk_sys, .rst, .fire, .run_stop(rs),
        .async_schedule_enable(ase), .periodic_schedule_enable(pse), .ev,
        .async_running(ar), .periodic_running(pr), .async_list_empty(ae),
        .execution_stopped(es));
    task cmp(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task cmp_irq(input logic e);
        cmp({32'h0, irq}, {32'h0, e});
    endtask : cmp_irq
    task cmp_cfg(input logic [13:0] e);
        cmp({19'h0, cfg}, {19'h0, e});
    endtask : cmp_cfg
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task fire_ev(input logic [5:0] v);
        fire <= v;
        @(posedge clk_sys);
        fire <= 6'h00;
    endtask : fire_ev
    task finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    // Read results are matched in order of request
    always @(posedge clk_sys) begin
        if (pready === 1'b1 && pwrite === 1'b0) cmp({pslverr, prdata},
            q.pop_front());
    end
    initial begin
        #160000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        logic [31:0] d;
        int          n;
        static logic [7:0] thr [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                       8'h20, 8'h40};
        void'($urandom(33292));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        cmp_cfg(14'h0708);
        rd(8'h10, 33'h0_0008_0b00);
        rd(8'h14, 33'h0_0000_1000);
        rd(8'h18, 33'h0_0000_0000);
        rd(8'h1c, 33'h1_0000_0000);
        apb(1'b1, 8'h10, 32'hffff_fbfd);
        rd(8'h10, 33'h0_0008_0b71);
        rd(8'h14, 33'h0_0000_c000);
        apb(1'b1, 8'h10, 32'h0);
        fire_ev(6'h20);
        repeat (4) @(posedge clk_sys);
        rd(8'h14, 33'h0_0000_1020);
        apb(1'b1, 8'h14, 32'h0000_0020);
        rd(8'h14, 33'h0_0000_1000);
        $display("test control and halt done");
        foreach (thr[i]) begin
            d = {8'h00, thr[i], 12'h000, 2'($urandom % 3), 2'h0};
            apb(1'b1, 8'h10, d);
            apb(1'b1, 8'h10, 32'h0000_000c);
            rd(8'h10, {1'b0, d});
            cmp_cfg({1'b0, d[3:2], 3'h0, thr[i]});
        end
        $display("test threshold codes done");
        apb(1'b1, 8'h10, 32'h0001_0020);
        rd(8'h14, 33'h0_0000_3000);
        apb(1'b1, 8'h18, 32'hffff_ffff);
        rd(8'h18, 33'h0_0000_003f);
        for (int i = 0; i < 6; i++) begin
            if (i == 5) apb(1'b1, 8'h10, 32'h0001_0060);
            fire_ev(6'(1 << i));
            repeat (6) @(posedge clk_sys);
            cmp_irq(1'b1);
            rd(8'h14, {1'b0, 32'h3000 | 32'(1 << i)});
            apb(1'b1, 8'h14, 32'(1 << i));
            repeat (4) @(posedge clk_sys);
            cmp_irq(1'b0);
        end
        apb(1'b1, 8'h18, 32'h0);
        fire_ev(6'h01);
        repeat (6) @(posedge clk_sys);
        cmp_irq(1'b0);
        apb(1'b1, 8'h14, 32'h0);
        rd(8'h14, 33'h0_0000_3001);
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b1, 8'h10, 32'h0040_0020);
        apb(1'b1, 8'h18, 32'h1);
        fire_ev(6'h01);
        repeat (6) @(posedge clk_sys);
        cmp_irq(1'b0);
        repeat (600) begin
            @(posedge clk_sys);
            if (irq === 1'b1) break;
        end
        cmp_irq(1'b1);
        $display("test events done");
        apb(1'b1, 8'h14, 32'h1);
        fs <= 1'b1;
        fire_ev(6'h01);
        repeat (6) @(posedge clk_sys);
        cmp_irq(1'b1);
        apb(1'b1, 8'h14, 32'h1);
        edge_ctl <= 1'b1;
        min_w    <= 8'h03;
        repeat (4) @(posedge clk_sys);
        fire_ev(6'h01);
        repeat (12) begin
            @(posedge clk_sys);
            n += int'(irq);
        end
        cmp(33'(n), 33'h4);
        cmp_irq(1'b0);
        apb(1'b1, 8'h14, 32'h1);
        fs       <= 1'b0;
        edge_ctl <= 1'b0;
        min_w    <= 8'h00;
        $display("test edge and full speed done");
        apb(1'b1, 8'h10, 32'h0000_0002);
        repeat (3) @(posedge clk_sys);
        cmp_cfg(14'h0708);
        rd(8'h10, 33'h0_0008_0b00);
        rd(8'h14, 33'h0_0000_1000);
        rd(8'h18, 33'h0_0000_0000);
        $display("test soft reset done");
        finish_test();
    end
endmodule : tb_top
